// File: src/putb_timebase.sv
`timescale 1ns/1ps

`include "putb_cfg.svh"


module putb_timebase
    import putb_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic timer0_overflow_i,
    input wire logic external_count_input_i,
    input wire logic [3:0] port_out_i,
    output logic [3:0] pin_o,
    output logic [3:0] unit_owns_pin_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] control_q;
    logic [7:0] mode_q;
    putb_word_t period_q;
    putb_word_t shadow_period_q;
    putb_word_t count_q;
    putb_word_t cmp_q [3];
    logic [2:0] pwm;
    logic ext_meta_q;
    logic ext_sync_q;
    logic ext_prev_q;
    logic tick;
    logic wrap;
    logic load_shadow;
    logic wr_en;
    logic [31:0] rd_data;
    putb_src_e src;

    function automatic logic is_cmp(input logic [7:0] adr, input int idx, input logic hi);
        is_cmp = adr == 8'(`PUTB_OFS_CMP_HI0 + idx * `PUTB_OFS_CMP_STEP
            + (hi ? 0 : 4));
    endfunction : is_cmp

    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

    // One wait state; ack drops the cycle after it is given
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Count source

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end
        else
        begin
            ext_meta_q <= external_count_input_i;
            ext_sync_q <= ext_meta_q;
            ext_prev_q <= ext_sync_q;
        end
    end

    assign src = putb_src_e'(mode_q[`PUTB_MOD_SRC_HI:`PUTB_MOD_SRC_LO]);

    // Reserved source never advances the counter
    always_comb
    begin
        unique case (src)
            PUTB_SRC_CLK: tick = 1'b1;
            PUTB_SRC_RSVD: tick = 1'b0;
            PUTB_SRC_T0OVF: tick = timer0_overflow_i;
            PUTB_SRC_EXT: tick = ext_sync_q && !ext_prev_q;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Time base

    assign wrap = control_q[`PUTB_CTL_RUN] && tick && count_q >= shadow_period_q;
    assign load_shadow = !control_q[`PUTB_CTL_RUN]
        || (wrap && control_q[`PUTB_CTL_UPDATE]);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            count_q <= `PUTB_RST_COUNT;
        else if (wrap)
            count_q <= `PUTB_RST_COUNT;
        else if (control_q[`PUTB_CTL_RUN] && tick)
            count_q <= count_q + 16'h0001;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            shadow_period_q <= `PUTB_RST_PERIOD;
        else if (load_shadow)
            shadow_period_q <= period_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            control_q <= `PUTB_RST_CONTROL;
        else
        begin
            if (wr_en && wb_adr_i == `PUTB_OFS_CONTROL)
                control_q <= {wb_dat_i[7:6], 2'h0, wb_dat_i[3:0]};
            // Hardware clear loses to a fresh software set in the same cycle
            if (wrap && control_q[`PUTB_CTL_UPDATE]
                && !(wr_en && wb_adr_i == `PUTB_OFS_CONTROL && wb_dat_i[7]))
                control_q[`PUTB_CTL_UPDATE] <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_q <= `PUTB_RST_MODE;
            period_q <= `PUTB_RST_PERIOD;
        end
        else if (wr_en)
        begin
            if (wb_adr_i == `PUTB_OFS_MODE)
                mode_q <= {wb_dat_i[7:6], 3'h0, wb_dat_i[2:0]};
            if (wb_adr_i == `PUTB_OFS_PERIOD_HI)
                period_q[15:8] <= wb_dat_i[7:0];
            if (wb_adr_i == `PUTB_OFS_PERIOD_LO)
                period_q[7:0] <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cmp_q <= '{`PUTB_RST_CMP, `PUTB_RST_CMP, `PUTB_RST_CMP};
        else if (wr_en)
            for (int i = 0; i < 3; i++)
            begin
                if (is_cmp(wb_adr_i, i, 1'b1))
                    cmp_q[i][15:8] <= wb_dat_i[7:0];
                if (is_cmp(wb_adr_i, i, 1'b0))
                    cmp_q[i][7:0] <= wb_dat_i[7:0];
            end
    end

    always_comb
    begin
        rd_data = 32'h0000_0000;
        case (wb_adr_i)
            `PUTB_OFS_CONTROL: rd_data[7:0] = control_q;
            `PUTB_OFS_MODE: rd_data[7:0] = mode_q;
            `PUTB_OFS_PERIOD_HI: rd_data[7:0] = period_q[15:8];
            `PUTB_OFS_PERIOD_LO: rd_data[7:0] = period_q[7:0];
            `PUTB_OFS_COUNT_HI: rd_data[7:0] = count_q[15:8];
            `PUTB_OFS_COUNT_LO: rd_data[7:0] = count_q[7:0];
            default:
                for (int i = 0; i < 3; i++)
                begin
                    if (is_cmp(wb_adr_i, i, 1'b1))
                        rd_data[7:0] = cmp_q[i][15:8];
                    if (is_cmp(wb_adr_i, i, 1'b0))
                        rd_data[7:0] = cmp_q[i][7:0];
                end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (wb_cyc_i && wb_stb_i && !wb_ack_o)
            wb_dat_o <= rd_data;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Modules and pins

    for (genvar g = 0; g < 3; g++)
    begin : g_mod
        putb_cmp_module u_mod (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .enable_i(control_q[g]),
            .invert_i(mode_q[g]),
            .load_i(load_shadow),
            .cmp_value_i(cmp_q[g]),
            .count_i(count_q),
            .pwm_o(pwm[g])
        );
    end

    // Pin order: 0 count input, 1 module 0, 2 module 1, 3 module 2
    always_comb
    begin
        unit_owns_pin_o = {control_q[2:0], src == PUTB_SRC_EXT};
        pin_o[0] = port_out_i[0];
        pin_o[1] = control_q[0] ? pwm[0] : port_out_i[1];
        pin_o[2] = !control_q[1] ? port_out_i[2]
            : (control_q[`PUTB_CTL_PINSEL] ? pwm[1] ^ pwm[2] : pwm[1]);
        pin_o[3] = control_q[2] ? pwm[2] : port_out_i[3];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_wrap_req;
        wrap && control_q[`PUTB_CTL_UPDATE];
    endsequence

    AST_WRAP_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        wrap |=> count_q == 16'h0000)
        else $error("Counter did not reload zero at wrap");

    AST_UPDATE_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
        s_wrap_req |=> shadow_period_q == $past(period_q))
        else $error("Shadow period not loaded at wrap");

    AST_UPDATE_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_wrap_req and !wr_en) |=> !control_q[`PUTB_CTL_UPDATE])
        else $error("Update request not cleared after load");

    AST_STOP_COPY: assert property (@(posedge clk_i) disable iff (rst_i)
        !control_q[`PUTB_CTL_RUN] |=> shadow_period_q == $past(period_q))
        else $error("Shadow not following period while stopped");

    AST_STOP_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        !control_q[`PUTB_CTL_RUN] |=> $stable(count_q))
        else $error("Counter moved while stopped");

    AST_CLK_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
        control_q[`PUTB_CTL_RUN] && src == PUTB_SRC_CLK && !wrap
        |=> count_q == $past(count_q) + 16'h0001)
        else $error("Counter did not step on clock source");

    AST_RSVD_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
        src == PUTB_SRC_RSVD |=> $stable(count_q))
        else $error("Reserved source advanced the counter");

    AST_UNUSED_BITS: assert property (@(posedge clk_i) disable iff (rst_i)
        control_q[5:4] == 2'h0)
        else $error("Unused control bits not zero");

    AST_PIN_XOR: assert property (@(posedge clk_i) disable iff (rst_i)
        control_q[1] && control_q[`PUTB_CTL_PINSEL] |-> pin_o[2] == (pwm[1] ^ pwm[2]))
        else $error("Module one pin select wrong");

    AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("Ack held longer than one cycle");

endmodule : putb_timebase

// File: inc/putb_cfg.svh
`ifndef PUTB_CFG_SVH
`define PUTB_CFG_SVH

// Byte offsets of the registers on the 32-bit Wishbone bus
`define PUTB_OFS_CONTROL 8'hE8
`define PUTB_OFS_MODE 8'hEC
`define PUTB_OFS_PERIOD_HI 8'hF0
`define PUTB_OFS_PERIOD_LO 8'hF4
`define PUTB_OFS_COUNT_HI 8'hF8
`define PUTB_OFS_COUNT_LO 8'hFC
`define PUTB_OFS_CMP_HI0 8'hD0
`define PUTB_OFS_CMP_LO0 8'hD4
`define PUTB_OFS_CMP_STEP 8'h08

// Control register fields
`define PUTB_CTL_UPDATE 7
`define PUTB_CTL_RUN 6
`define PUTB_CTL_PINSEL 3
`define PUTB_CTL_EN_HI 2

// Mode register fields
`define PUTB_MOD_SRC_HI 7
`define PUTB_MOD_SRC_LO 6
`define PUTB_MOD_INV_HI 2

// Reset values
`define PUTB_RST_CONTROL 8'h00
`define PUTB_RST_MODE 8'h00
`define PUTB_RST_PERIOD 16'hFFFF
`define PUTB_RST_COUNT 16'h0000
`define PUTB_RST_CMP 16'h0000

`endif

// File: inc/putb_pkg.sv
package putb_pkg;

    typedef enum logic [1:0] {
        PUTB_SRC_CLK = 2'h0,
        PUTB_SRC_RSVD = 2'h1,
        PUTB_SRC_T0OVF = 2'h2,
        PUTB_SRC_EXT = 2'h3
    } putb_src_e;

    typedef logic [15:0] putb_word_t;

endpackage : putb_pkg

// File: src/putb_cmp_module.sv
`timescale 1ns/1ps

`include "putb_cfg.svh"

module putb_cmp_module
    import putb_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic invert_i,
    input wire logic load_i,
    input wire putb_word_t cmp_value_i,
    input wire putb_word_t count_i,
    output logic pwm_o
);

    putb_word_t shadow_cmp_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            shadow_cmp_q <= `PUTB_RST_CMP;
        else if (load_i)
            shadow_cmp_q <= cmp_value_i;
    end

    // Disabled module rests at its idle level
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pwm_o <= 1'b0;
        else if (!enable_i)
            pwm_o <= invert_i;
        else if (count_i < shadow_cmp_q)
            pwm_o <= invert_i;
        else
            pwm_o <= ~invert_i;
    end

    AST_CMP_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
        enable_i && !rst_i |=> pwm_o == ($past(count_i) < $past(shadow_cmp_q)
            ? $past(invert_i) : ~$past(invert_i)))
        else $error("Module output level does not follow compare");

endmodule : putb_cmp_module

// File: dv/putb_timebase_tb_top.sv
`timescale 1ns/1ps

`include "putb_cfg.svh"

module putb_timebase_tb_top
    import putb_pkg::*;
;

typedef struct {logic [7:0] adr; logic we; logic [7:0] wd; logic [7:0] exp;} putb_row_s;

logic clk_i = 1'b0;
logic rst_i = 1'b1;
logic cyc = 1'b0;
logic stb = 1'b0;
logic we = 1'b0;
logic [7:0] adr = 8'h00;
logic [3:0] sel = 4'hF;
logic [31:0] wdat = 32'h00000000;
logic t0 = 1'b0;
logic ext = 1'b0;
logic [3:0] port = 4'h0;
logic [31:0] wb_dat_o;
logic wb_ack_o;
logic [3:0] pin_o;
logic [3:0] owns;
logic [31:0] rd;
logic [31:0] c0;
int err_total = 0;
int total_checks = 0;
int cycles = 0;
int h;

// Reset values first, then field masks, then the unmapped and read-only places
putb_row_s rows [18] = '{
    '{8'hE8, 1'b0, 8'h00, 8'h00}, '{8'hEC, 1'b0, 8'h00, 8'h00}, '{8'hF0, 1'b0, 8'h00, 8'hFF},
    '{8'hF4, 1'b0, 8'h00, 8'hFF}, '{8'hF8, 1'b0, 8'h00, 8'h00}, '{8'hFC, 1'b0, 8'h00, 8'h00},
    '{8'hD0, 1'b0, 8'h00, 8'h00}, '{8'hE4, 1'b0, 8'h00, 8'h00}, '{8'hE8, 1'b1, 8'h37, 8'h00},
    '{8'hE8, 1'b0, 8'h00, 8'h07}, '{8'hEC, 1'b1, 8'hFF, 8'h00}, '{8'hEC, 1'b0, 8'h00, 8'hC7},
    '{8'h10, 1'b1, 8'h55, 8'h00}, '{8'h10, 1'b0, 8'h00, 8'h00}, '{8'hF8, 1'b1, 8'h12, 8'h00},
    '{8'hF8, 1'b0, 8'h00, 8'h00}, '{8'hE8, 1'b1, 8'h00, 8'h00}, '{8'hEC, 1'b1, 8'h00, 8'h00}};

always #2.5 clk_i = ~clk_i;

putb_timebase putb_timebase_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .timer0_overflow_i(t0),
    .external_count_input_i(ext),
    .port_out_i(port),
    .pin_o(pin_o),
    .unit_owns_pin_o(owns)
);

////////////////////////////////////////////////////////////////////////////////

task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
    begin
        $display("Testbench passed");
    end
    else
    begin
        $display("Testbench failed");
    end
    $finish;
endtask : finish_test

task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
        $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        err_total++;
    end
endtask : check

// Ack is read as sampled by the edge, so no wait-state count is assumed
task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= a;
    we <= w;
    wdat <= {24'h000000, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
    begin
        @(posedge clk_i);
    end
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
endtask : wb

task automatic highs(input int b, output int n);
    n = 0;
    repeat (16)
    begin
        @(posedge clk_i);
        if (pin_o[b] === 1'b1)
            n++;
    end
endtask : highs

always @(posedge clk_i)
begin
    cycles++;
    if (cycles == 20000)
    begin
        err_total++;
        finish_test();
    end
end

////////////////////////////////////////////////////////////////////////////////

initial
begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i])
    begin
        wb(rows[i].adr, rows[i].we, rows[i].wd);
        if (!rows[i].we)
            check("register", {24'h000000, rows[i].exp}, rd);
    end
    $display("done register table");
    port <= 4'hA;
    repeat (2) @(posedge clk_i);
    check("idle pins", 32'hA, pin_o);
    check("idle ownership", 32'h0, owns);
    $display("done port sharing");
    // Period 3 and compare 2 loaded while stopped: two high of every four
    wb(8'hF0, 1'b1, 8'h00);
    wb(8'hF4, 1'b1, 8'h03);
    wb(8'hD4, 1'b1, 8'h02);
    wb(8'hE8, 1'b1, 8'h41);
    highs(1, h);
    check("highs period 3", 8, h);
    wb(8'hF4, 1'b1, 8'h07);
    highs(1, h);
    check("highs no update", 8, h);
    wb(8'hE8, 1'b1, 8'hC1);
    repeat (10)
    begin
        wb(8'hE8, 1'b0, 8'h00);
        if (rd[7] === 1'b0)
            break;
    end
    check("update cleared", 32'h41, rd);
    highs(1, h);
    check("highs period 7", 12, h);
    $display("done timebase");
    wb(8'hE8, 1'b1, 8'h01);
    wb(8'hFC, 1'b0, 8'h00);
    c0 = rd;
    repeat (6) @(posedge clk_i);
    wb(8'hFC, 1'b0, 8'h00);
    check("stopped count", c0, rd);
    $display("done stop");
    // Zero compares: every enabled module sits at the level opposite its invert bit
    wb(8'hE8, 1'b1, 8'h46);
    repeat (3) @(posedge clk_i);
    check("module pins", 32'h3, pin_o[3:2]);
    check("ownership", 32'h6, owns[3:1]);
    wb(8'hE8, 1'b1, 8'h4E);
    repeat (3) @(posedge clk_i);
    check("xor pin", 32'h2, pin_o[3:2]);
    wb(8'hEC, 1'b1, 8'h04);
    repeat (3) @(posedge clk_i);
    check("inverted pin", 32'h1, pin_o[3:2]);
    $display("done module pins");
    wb(8'hE8, 1'b1, 8'h00);
    wb(8'hF4, 1'b1, 8'hFF);
    wb(8'hEC, 1'b1, 8'h80);
    wb(8'hE8, 1'b1, 8'h40);
    wb(8'hFC, 1'b0, 8'h00);
    c0 = rd;
    repeat (5)
    begin
        t0 <= 1'b1;
        @(posedge clk_i);
        t0 <= 1'b0;
        @(posedge clk_i);
    end
    wb(8'hFC, 1'b0, 8'h00);
    check("overflow count", c0 + 32'h5, rd);
    wb(8'hEC, 1'b1, 8'hC0);
    check("input owned", 32'h1, owns[0]);
    wb(8'hFC, 1'b0, 8'h00);
    c0 = rd;
    // Four-cycle phases keep the pin under a quarter of the clock rate
    repeat (3)
    begin
        ext <= 1'b1;
        repeat (4) @(posedge clk_i);
        ext <= 1'b0;
        repeat (4) @(posedge clk_i);
    end
    wb(8'hFC, 1'b0, 8'h00);
    check("edge count", c0 + 32'h3, rd);
    // Reserved source must ignore both count inputs
    wb(8'hEC, 1'b1, 8'h40);
    wb(8'hFC, 1'b0, 8'h00);
    c0 = rd;
    t0 <= 1'b1;
    ext <= 1'b1;
    repeat (4) @(posedge clk_i);
    t0 <= 1'b0;
    ext <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(8'hFC, 1'b0, 8'h00);
    check("reserved count", c0, rd);
    $display("done count sources");
    // A write without its low byte lane selected must leave control alone
    sel <= 4'hE;
    wb(8'hE8, 1'b1, 8'h07);
    sel <= 4'hF;
    wb(8'hE8, 1'b0, 8'h00);
    check("masked write", 32'h40, rd);
    $display("done byte lanes");
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("reset pins", 32'hA, pin_o);
    wb(8'hE8, 1'b0, 8'h00);
    check("reset control", 32'h0, rd);
    wb(8'hF0, 1'b0, 8'h00);
    check("reset period", 32'hFF, rd);
    wb(8'hFC, 1'b0, 8'h00);
    check("reset count", 32'h0, rd);
    $display("done mid-run reset");
    finish_test();
end

endmodule : putb_timebase_tb_top
